// >>> verilog/tdp_pkg.sv
`default_nettype none
package tdp_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_COUNT = 8'h09;
  localparam logic [7:0] IDX_CTRL = 8'h0A;
  localparam logic [7:0] IDX_CTRL2 = 8'h0B;
  localparam logic [7:0] IDX_DUTY = 8'h0C;
  localparam logic [7:0] IDX_PSVAL = 8'h0D;
  localparam logic [7:0] IDX_HIGH = 8'h14;
  localparam logic [7:0] IDX_STAT = 8'h15;
  localparam logic [7:0] IDX_MASK = 8'h16;
  localparam logic [7:0] ADR_COUNT = {IDX_COUNT[5:0], 2'b00};
  localparam logic [7:0] ADR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADR_CTRL2 = {IDX_CTRL2[5:0], 2'b00};
  localparam logic [7:0] ADR_DUTY = {IDX_DUTY[5:0], 2'b00};
  localparam logic [7:0] ADR_PSVAL = {IDX_PSVAL[5:0], 2'b00};
  localparam logic [7:0] ADR_HIGH = {IDX_HIGH[5:0], 2'b00};
  localparam logic [7:0] ADR_STAT = {IDX_STAT[5:0], 2'b00};
  localparam logic [7:0] ADR_MASK = {IDX_MASK[5:0], 2'b00};
  // Control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_RLD = 1;
  localparam int CTL_OS = 2;
  localparam int CTL_AL = 6;
  localparam int CTL_OE = 7;
  localparam logic [7:0] CTL_WMASK = 8'hC7;
  // Second control register fields
  localparam int CT2_RATIO_LSB = 0;
  localparam int CT2_PSDIS = 3;
  localparam int CT2_EDGE = 4;
  localparam int CT2_SRC = 5;
  localparam logic [7:0] CT2_WMASK = 8'h3F;
  // Shared high bits: count reload in [7:6], duty in [3:2]
  localparam int HI_CNT_LSB = 6;
  localparam int HI_DUTY_LSB = 2;
  localparam int ST_UNDERFLOW = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h3F;
  localparam logic [7:0] RST_HIGH = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PSVAL = 8'hFF;
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [9:0] CNT_ALL_ONES = 10'h3FF;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  typedef enum logic [0:0] {RUN_GO = 1'b0, RUN_STOP = 1'b1} tdp_run_e;
endpackage : tdp_pkg
`default_nettype wire

// >>> verilog/tdp_ps_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tdp_ps_if;
  logic src_tick;
  logic bypass;
  logic [2:0] ratio;
  logic out_tick;
  logic [7:0] value;
  modport ctrl (output src_tick, output bypass, output ratio, input out_tick, input value);
  modport pre (input src_tick, input bypass, input ratio, output out_tick, output value);
endinterface : tdp_ps_if
`default_nettype wire

// >>> verilog/tdp_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tdp_prescale (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to the timer
  tdp_ps_if.pre ps
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] low_mask;

  // Low bits that must all be zero for a tick: ratio 0 gives 1:2, ratio 7 gives 1:256
  function automatic logic [7:0] tdp_ratio_mask(input logic [2:0] r);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      m[i] = (i <= int'(r));
    end
    return m;
  endfunction : tdp_ratio_mask

  always_comb
  begin
    low_mask = tdp_ratio_mask(ps.ratio);
    nxt_cnt = cnt_ff;
    if (ps.src_tick && !ps.bypass)
    begin
      nxt_cnt = cnt_ff - 8'h01;
    end
  end

  // Bypassed prescaler passes every source tick straight through [RL11]
  assign ps.out_tick = ps.src_tick && (ps.bypass || ((cnt_ff & low_mask) == 8'h00));
  assign ps.value = cnt_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= tdp_pkg::RST_PSVAL;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : tdp_prescale
`default_nettype wire

// >>> verilog/tdp_timer.sv
// Notes on behaviour
// RL1: Reading the count register gives the low eight bits of the live 10-bit down counter.
// RL2: Writing the count register loads the whole counter at once from the shared high bits and the written byte.
// RL3: The enable bit lets the timer count when set and holds it when clear.
// RL4: The reload-select bit matters only in non-stop mode and is ignored in one-shot mode.
// RL5: Non-stop with reload-select clear reloads 0x3FF after passing 0x00 and keeps counting.
// RL6: Non-stop with reload-select set reloads the stored reload value on every underflow and keeps counting.
// RL7: One-shot counts once down to 0x00 and then stops until software writes the count again.
// RL8: The active-low bit makes the pulse output active low when set and active high when clear.
// RL9: The output-enable bit puts the pulse waveform on its pin, otherwise the pin is plain GPIO.
// RL10: A source bit picks the instruction clock or the external pin, and an edge bit picks its falling or rising edge.
// RL11: A 3-bit ratio divides the count clock by 2 to 256, and software changes it only while the prescaler is off.
// RL12: The 10-bit reload value sets the pulse frame and a 10-bit duty value sets its active part.
// RL13: Every underflow gives a one-cycle event that sets the timer flag for software.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tdp_timer (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // External count clock pin
  input wire logic EXTERNAL_COUNT_INPUT,
  // Pulse pin and the GPIO it shares with
  input wire logic GPIO_OUT,
  input wire logic GPIO_OE,
  output logic PULSE_OUT_PIN,
  output logic PULSE_OUT_PIN_OE,
  // Interrupt and underflow event
  output logic IRQ,
  output logic UNDERFLOW
);
  tdp_ps_if ps ();

  // Bus state
  logic pready_ff, nxt_pready;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic [7:0] rclr_ff, nxt_rclr;
  // Registers
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] ctrl2_ff, nxt_ctrl2;
  logic [7:0] high_ff, nxt_high;
  logic [7:0] reload_ff, nxt_reload;
  logic [7:0] duty_ff, nxt_duty;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] mask_ff, nxt_mask;
  // Counter state
  logic [9:0] cnt_ff, nxt_cnt;
  tdp_pkg::tdp_run_e run_ff, nxt_run;
  logic uflow_ff, nxt_uflow;
  // External pin sampling
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  // Outputs
  logic pin_ff, nxt_pin;
  logic pin_oe_ff, nxt_pin_oe;
  logic irq_ff, nxt_irq;

  logic setup_ok, done, wr_done, is_mapped;
  logic [31:0] rd_word;
  logic ext_edge, count_step;
  logic [9:0] reload10, duty10;
  logic pulse_active;

  function automatic logic [31:0] tdp_byte(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction : tdp_byte

  assign setup_ok = PSEL && PENABLE;
  assign done = setup_ok && pready_ff;
  assign wr_done = done && PWRITE;

  // Read mux and address decode
  always_comb
  begin
    rd_word = 32'h0000_0000;
    is_mapped = 1'b1;
    case (PADDR)
      tdp_pkg::ADR_COUNT: rd_word = tdp_byte(cnt_ff[7:0]); // [RL1]
      tdp_pkg::ADR_CTRL: rd_word = tdp_byte(ctrl_ff & tdp_pkg::CTL_WMASK);
      tdp_pkg::ADR_CTRL2: rd_word = tdp_byte(ctrl2_ff & tdp_pkg::CT2_WMASK);
      tdp_pkg::ADR_DUTY: rd_word = tdp_byte(duty_ff);
      tdp_pkg::ADR_PSVAL: rd_word = tdp_byte(ps.value);
      tdp_pkg::ADR_HIGH: rd_word = tdp_byte(high_ff);
      tdp_pkg::ADR_STAT: rd_word = tdp_byte(stat_ff);
      tdp_pkg::ADR_MASK: rd_word = tdp_byte(mask_ff);
      default: is_mapped = 1'b0;
    endcase
  end

  // Bus answer: one wait state, data captured on the first access edge
  always_comb
  begin
    nxt_pready = setup_ok && !pready_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_rclr = rclr_ff;
    if (setup_ok && !pready_ff)
    begin
      nxt_prdata = PWRITE ? 32'h0000_0000 : rd_word;
      nxt_pslverr = !is_mapped;
      nxt_rclr = (!PWRITE && PADDR == tdp_pkg::ADR_STAT) ? stat_ff : 8'h00;
    end
    else if (done)
    begin
      nxt_rclr = 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      rclr_ff <= 8'h00;
    end
    else
    begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      rclr_ff <= nxt_rclr;
    end
  end

  // Register writes
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_high = high_ff;
    nxt_reload = reload_ff;
    nxt_duty = duty_ff;
    nxt_mask = mask_ff;
    if (wr_done)
    begin
      case (PADDR)
        tdp_pkg::ADR_COUNT: nxt_reload = PWDATA[7:0];
        tdp_pkg::ADR_CTRL: nxt_ctrl = PWDATA[7:0] & tdp_pkg::CTL_WMASK;
        tdp_pkg::ADR_CTRL2: nxt_ctrl2 = PWDATA[7:0] & tdp_pkg::CT2_WMASK;
        tdp_pkg::ADR_DUTY: nxt_duty = PWDATA[7:0];
        tdp_pkg::ADR_HIGH: nxt_high = PWDATA[7:0];
        tdp_pkg::ADR_MASK: nxt_mask = PWDATA[7:0];
        default: nxt_mask = mask_ff;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_ff <= tdp_pkg::RST_CTRL;
      ctrl2_ff <= tdp_pkg::RST_CTRL2;
      high_ff <= tdp_pkg::RST_HIGH;
      reload_ff <= 8'h00;
      duty_ff <= tdp_pkg::RST_DUTY;
      mask_ff <= 8'h00;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      ctrl2_ff <= nxt_ctrl2;
      high_ff <= nxt_high;
      reload_ff <= nxt_reload;
      duty_ff <= nxt_duty;
      mask_ff <= nxt_mask;
    end
  end

  // External pin passes three flops; the edge is taken between the second and third
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end
    else
    begin
      ext_s1_ff <= EXTERNAL_COUNT_INPUT;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // Edge bit set means falling edge, clear means rising edge [RL10]
  assign ext_edge = ctrl2_ff[tdp_pkg::CT2_EDGE] ? (ext_s3_ff && !ext_s2_ff) : (!ext_s3_ff && ext_s2_ff);
  // Instruction clock is taken as one tick per system clock [RL10]
  assign ps.src_tick = ctrl2_ff[tdp_pkg::CT2_SRC] ? ext_edge : 1'b1;
  assign ps.bypass = ctrl2_ff[tdp_pkg::CT2_PSDIS];
  assign ps.ratio = ctrl2_ff[tdp_pkg::CT2_RATIO_LSB +: 3]; // [RL11]

  tdp_prescale u_prescale (
    .clk (CLK),
    .nrst (NRST),
    .ps (ps)
  );

  assign reload10 = {high_ff[tdp_pkg::HI_CNT_LSB +: 2], reload_ff};
  assign duty10 = {high_ff[tdp_pkg::HI_DUTY_LSB +: 2], duty_ff}; // [RL12]
  assign count_step = ps.out_tick && ctrl_ff[tdp_pkg::CTL_EN] && (run_ff == tdp_pkg::RUN_GO); // [RL3]

  // Down counter
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_uflow = 1'b0;
    if (wr_done && PADDR == tdp_pkg::ADR_COUNT)
    begin
      // A count write restarts a stopped one-shot as well
      nxt_cnt = {high_ff[tdp_pkg::HI_CNT_LSB +: 2], PWDATA[7:0]}; // [RL2]
      nxt_run = tdp_pkg::RUN_GO; // [RL7]
    end
    else if (count_step)
    begin
      if (cnt_ff == tdp_pkg::CNT_ZERO)
      begin
        nxt_uflow = 1'b1; // [RL13]
        case (run_ff)
          tdp_pkg::RUN_GO:
          begin
            if (ctrl_ff[tdp_pkg::CTL_OS])
            begin
              nxt_run = tdp_pkg::RUN_STOP; // [RL7] [RL4]
            end
            else if (ctrl_ff[tdp_pkg::CTL_RLD])
            begin
              nxt_cnt = reload10; // [RL6]
            end
            else
            begin
              nxt_cnt = tdp_pkg::CNT_ALL_ONES; // [RL5]
            end
          end
          default: nxt_run = tdp_pkg::RUN_STOP;
        endcase
      end
      else
      begin
        nxt_cnt = cnt_ff - 10'h001;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cnt_ff <= tdp_pkg::RST_COUNT;
      run_ff <= tdp_pkg::RUN_GO;
      uflow_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      uflow_ff <= nxt_uflow;
    end
  end

  // Pulse output: active while the count sits below the duty value, so duty 0 never goes active
  assign pulse_active = (cnt_ff < duty10); // [RL12]

  // Status, interrupt and pin; a flag set in the clearing cycle survives because the set is applied after the clear
  always_comb
  begin
    nxt_stat = stat_ff;
    if (done && !PWRITE && PADDR == tdp_pkg::ADR_STAT)
    begin
      nxt_stat = stat_ff & ~rclr_ff;
    end
    if (nxt_uflow)
    begin
      nxt_stat[tdp_pkg::ST_UNDERFLOW] = 1'b1; // [RL13]
    end
    nxt_irq = |(nxt_stat & mask_ff);
    if (ctrl_ff[tdp_pkg::CTL_OE])
    begin
      nxt_pin = pulse_active ^ ctrl_ff[tdp_pkg::CTL_AL]; // [RL8] [RL9]
      nxt_pin_oe = 1'b1; // [RL9]
    end
    else
    begin
      nxt_pin = GPIO_OUT; // [RL9]
      nxt_pin_oe = GPIO_OE;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      stat_ff <= 8'h00;
      irq_ff <= 1'b0;
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      irq_ff <= nxt_irq;
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign PULSE_OUT_PIN = pin_ff;
  assign PULSE_OUT_PIN_OE = pin_oe_ff;
  assign IRQ = irq_ff;
  assign UNDERFLOW = uflow_ff;
endmodule : tdp_timer
`default_nettype wire

// >>> sim/tdp_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tdp_timer_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // Pins and events
  input wire logic EXTERNAL_COUNT_INPUT,
  input wire logic GPIO_OUT,
  input wire logic GPIO_OE,
  input wire logic PULSE_OUT_PIN,
  input wire logic PULSE_OUT_PIN_OE,
  input wire logic IRQ,
  input wire logic UNDERFLOW
);
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic stop_ff;
  logic nxt_stop;
  logic wr_done;
  logic mask_wr;
  logic en;
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign mask_wr = wr_done && PADDR == tdp_pkg::ADR_MASK;
  assign en = ctl_ff[tdp_pkg::CTL_EN];
  // Shadow of the control byte, seen from the bus, and of the one-shot stop, seen from the bus and UNDERFLOW
  always_comb
  begin
    nxt_ctl = ctl_ff;
    nxt_stop = stop_ff;
    if (wr_done && PADDR == tdp_pkg::ADR_CTRL)
      nxt_ctl = PWDATA[7:0];
    if (wr_done && (PADDR == tdp_pkg::ADR_CTRL || PADDR == tdp_pkg::ADR_COUNT))
      nxt_stop = 1'b0;
    else if (UNDERFLOW && ctl_ff[tdp_pkg::CTL_OS])
      nxt_stop = 1'b1;
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctl_ff <= 8'h00;
      stop_ff <= 1'b0;
    end
    else
    begin
      ctl_ff <= nxt_ctl;
      stop_ff <= nxt_stop;
    end
  end
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  ready_late_a: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("PREADY not in second access cycle");
  ready_once_a: assert property (PREADY |=> !PREADY)
    else $error("PREADY longer than one cycle");
  err_ready_a: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("PSLVERR outside completion");
  rd_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
    else $error("PRDATA upper bits set");
  gpio_pass_a: assert property (!ctl_ff[tdp_pkg::CTL_OE] |=>
    PULSE_OUT_PIN == $past(GPIO_OUT) && PULSE_OUT_PIN_OE == $past(GPIO_OE)) else $error("GPIO not passed");
  pulse_oe_a: assert property (ctl_ff[tdp_pkg::CTL_OE] |=> PULSE_OUT_PIN_OE)
    else $error("Pulse pin not driven");
  // An underflow raises its event and the interrupt at the same edge, so it is looked at in the same cycle
  irq_cause_a: assert property ($rose(IRQ) |-> UNDERFLOW || $past(mask_wr) || $past(mask_wr, 2))
    else $error("IRQ rose without cause");
  os_stop_a: assert property (stop_ff |-> !UNDERFLOW)
    else $error("Underflow after one-shot stop");
  en_hold_a: assert property (!en && !$past(en) && !$past(en, 2) |-> !UNDERFLOW)
    else $error("Underflow while disabled");
  cover property (UNDERFLOW);
  cover property (PSLVERR);
  cover property ($rose(IRQ));
endmodule : tdp_timer_checker
bind tdp_timer tdp_timer_checker u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
  .PSLVERR(PSLVERR), .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE(GPIO_OE), .PULSE_OUT_PIN(PULSE_OUT_PIN), .PULSE_OUT_PIN_OE(PULSE_OUT_PIN_OE),
  .IRQ(IRQ), .UNDERFLOW(UNDERFLOW));
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext = 1'b0;
  logic gpo = 1'b0;
  logic gpe = 1'b0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic pin;
  logic pin_oe;
  logic irq;
  logic uflow;
  int fail_count = 0;
  int n_compared = 0;
  logic [32:0] exp_q [$];
  logic [7:0] r;
  int i;
  int k;
  always #5 clk = ~clk;
  tdp_timer u_dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .EXTERNAL_COUNT_INPUT(ext), .GPIO_OUT(gpo), .GPIO_OE(gpe), .PULSE_OUT_PIN(pin),
    .PULSE_OUT_PIN_OE(pin_oe), .IRQ(irq), .UNDERFLOW(uflow));
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [32:0] exp, input logic [32:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic hang();
    fail_count++;
    finish_test();
  endtask : hang
  // One idle cycle between transfers keeps each strobe to one assignment per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e);
    int n;
    @(posedge clk);
    if (!wr)
      exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      hang();
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h00, {25'h000_0000, d});
  endtask : rd
  task automatic wait_uf(input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (uflow !== 1'b1 && n < lim);
    if (uflow !== 1'b1)
      hang();
  endtask : wait_uf
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read", exp_q.pop_front(), {pslverr, prdata});
  end
  initial
  begin
    i = $urandom(32'hC1EF_8D36);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(tdp_pkg::ADR_CTRL, tdp_pkg::RST_CTRL);
    rd(tdp_pkg::ADR_CTRL2, tdp_pkg::RST_CTRL2);
    rd(tdp_pkg::ADR_PSVAL, tdp_pkg::RST_PSVAL);
    rd(tdp_pkg::ADR_STAT, 8'h00);
    apb(1'b0, 8'h00, 8'h00, {1'b1, 32'h0000_0000});
    wr(tdp_pkg::ADR_CTRL2, 8'h08);
    wr(tdp_pkg::ADR_HIGH, 8'hC0);
    r = 8'($urandom());
    wr(tdp_pkg::ADR_COUNT, r);
    rd(tdp_pkg::ADR_COUNT, r);
    repeat (20) @(posedge clk);
    rd(tdp_pkg::ADR_COUNT, r);
    // Run time from the enable shows the two upper bits were taken
    wr(tdp_pkg::ADR_CTRL, 8'h07);
    wait_uf(1100, k);
    check("uf_time", 33'h0_0000_0001, 33'(k >= 'h300 + int'(r) && k <= 'h306 + int'(r)));
    repeat (3) @(posedge clk);
    check("irq", 33'h0_0000_0000, 33'(irq));
    repeat (300) @(posedge clk);
    rd(tdp_pkg::ADR_COUNT, 8'h00);
    wr(tdp_pkg::ADR_MASK, 8'h01);
    repeat (3) @(posedge clk);
    check("irq", 33'h0_0000_0001, 33'(irq));
    rd(tdp_pkg::ADR_STAT, 8'h01);
    repeat (3) @(posedge clk);
    check("irq", 33'h0_0000_0000, 33'(irq));
    wr(tdp_pkg::ADR_HIGH, 8'h00);
    wr(tdp_pkg::ADR_CTRL2, 8'h0B);
    wr(tdp_pkg::ADR_CTRL2, 8'h03);
    for (i = 0; i < 2; i++)
    begin
      wr(tdp_pkg::ADR_COUNT, 8'h12);
      wr(tdp_pkg::ADR_CTRL, 8'(1 + 2 * i));
      wait_uf(1000, k);
      // Nineteen ticks at 1:16 from the load, with the prescaler phase unknown by up to one period
      check("uf_time", 33'h0_0000_0001, 33'(k >= 286 && k <= 301));
      rd(tdp_pkg::ADR_COUNT, i ? 8'h12 : 8'hFF);
    end
    // Three toggles give two edges of the selected kind and one of the other
    for (i = 0; i < 2; i++)
    begin
      wr(tdp_pkg::ADR_CTRL2, 8'(8'h28 + 16 * i));
      wr(tdp_pkg::ADR_COUNT, 8'h10);
      repeat (3)
      begin
        repeat (6) @(posedge clk);
        ext <= ~ext;
      end
      repeat (8) @(posedge clk);
      rd(tdp_pkg::ADR_COUNT, 8'h0E);
    end
    wr(tdp_pkg::ADR_CTRL, 8'h00);
    wr(tdp_pkg::ADR_COUNT, 8'h05);
    for (i = 0; i < 4; i++)
    begin
      wr(tdp_pkg::ADR_HIGH, i > 1 ? 8'h0C : 8'h00);
      wr(tdp_pkg::ADR_DUTY, i > 1 ? 8'hFF : 8'h00);
      wr(tdp_pkg::ADR_CTRL, 8'(8'h80 + 64 * (i % 2)));
      repeat (3) @(posedge clk);
      check("pin", 33'(2 + ((i / 2) ^ (i % 2))), 33'({pin_oe, pin}));
    end
    wr(tdp_pkg::ADR_CTRL, 8'h00);
    repeat (4)
    begin
      {gpe, gpo} <= 2'($urandom());
      repeat (3) @(posedge clk);
      check("gpio", 33'({gpe, gpo}), 33'({pin_oe, pin}));
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
